// ---- design/adsp_device.sv ----
// Converter end: serial shifter on the link clock, DAC registers and
// conversion control on the system clock.
// Assumes the host drives the link clock only inside a chip-select frame.
//
// How it works
// - Modes 00/01/10 shift output on falling edge
// - Mode 11 shifts output on rising edge
// - Output is high impedance while select high
// - Input bit taken on serial clock falling edge
// - Clock and data ignored unless select low
// - End-of-conversion driven low when result ready
// - Low update input makes DAC registers transparent
// - Power-up select sets input registers ones/zeros
`timescale 1ns/100ps
module adsp_device #(
  parameter int NUM_DAC = adsp_pkg::NUM_DAC
) (
  // Link pins
  adsp_if.device                              link,
  // System clock and reset
  input  wire logic                           clock,
  input  wire logic                           rst,
  // Converter core
  input  wire logic [1:0]                     clock_mode,
  input  wire logic [adsp_pkg::ADC_BITS-1:0]  conv_data,
  output logic                                conv_start,
  output logic                                busy,
  output logic [NUM_DAC-1:0][adsp_pkg::DAC_BITS-1:0] dac_value
);

  typedef enum {ADSP_INIT, ADSP_IDLE, ADSP_CONV} adsp_core_t;

  // Link domain state
  logic                               frame_clr;
  logic                               mode_s1;
  logic                               mode_s2;
  logic                               next_mode_s1;
  logic                               next_mode_s2;
  logic [adsp_pkg::CNT_BITS-1:0]      fall_cnt;
  logic [adsp_pkg::CNT_BITS-1:0]      next_fall_cnt;
  logic [adsp_pkg::CNT_BITS-1:0]      rise_cnt;
  logic [adsp_pkg::CNT_BITS-1:0]      next_rise_cnt;
  adsp_pkg::adsp_word_t               rx_shift;
  adsp_pkg::adsp_word_t               next_rx_shift;
  adsp_pkg::adsp_word_t               rx_word;
  adsp_pkg::adsp_word_t               next_rx_word;
  logic                               rx_toggle;
  logic                               next_rx_toggle;
  logic [adsp_pkg::CNT_BITS-1:0]      tx_idx;

  // Core domain state
  adsp_core_t                         state;
  adsp_core_t                         next_state;
  logic                               tog_s1;
  logic                               tog_s2;
  logic                               tog_s3;
  logic                               cs_s1;
  logic                               cs_s2;
  logic                               cs_s3;
  logic                               ps_s1;
  logic                               ps_s2;
  logic                               upd_s1;
  logic                               upd_s2;
  logic [8:0]                         cnt;
  logic [8:0]                         next_cnt;
  logic                               eoc_n;
  logic                               next_eoc_n;
  logic                               next_conv_start;
  adsp_pkg::adsp_word_t               tx_word;
  adsp_pkg::adsp_word_t               next_tx_word;
  logic [NUM_DAC-1:0][adsp_pkg::DAC_BITS-1:0] dac_input;
  logic [NUM_DAC-1:0][adsp_pkg::DAC_BITS-1:0] next_dac_input;
  logic [NUM_DAC-1:0][adsp_pkg::DAC_BITS-1:0] dac_hold;
  logic [NUM_DAC-1:0][adsp_pkg::DAC_BITS-1:0] next_dac_hold;
  logic                               word_evt;
  logic                               cs_rise;
  logic [3:0]                         op;

  // Frame reset while select is high
  assign frame_clr = rst | link.cs_n;

  // Mode bit synchroniser into the link domain
  always_comb begin
    next_mode_s1 = (clock_mode == adsp_pkg::MODE_RISE);
    next_mode_s2 = mode_s1;
  end

  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end else begin
      mode_s1 <= next_mode_s1;
      mode_s2 <= next_mode_s2;
    end
  end

  // Falling-edge side: input sampling and bit count
  always_comb begin
    next_fall_cnt  = fall_cnt;
    next_rx_shift  = rx_shift;
    if (fall_cnt < adsp_pkg::CNT_BITS'(adsp_pkg::WORD_BITS)) begin
      next_fall_cnt = fall_cnt + 1'b1;
      next_rx_shift = {rx_shift[adsp_pkg::WORD_BITS-2:0], link.din};
    end
  end

  always_ff @(negedge link.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      fall_cnt <= '0;
      rx_shift <= '0;
    end else begin
      fall_cnt <= next_fall_cnt;
      rx_shift <= next_rx_shift;
    end
  end

  // Whole word handed over with a toggle
  always_comb begin
    next_rx_word   = rx_word;
    next_rx_toggle = rx_toggle;
    if (!link.cs_n && fall_cnt == adsp_pkg::CNT_BITS'(adsp_pkg::WORD_BITS - 1)) begin
      next_rx_word   = {rx_shift[adsp_pkg::WORD_BITS-2:0], link.din};
      next_rx_toggle = ~rx_toggle;
    end
  end

  always_ff @(negedge link.sclk or posedge rst) begin
    if (rst) begin
      rx_word   <= '0;
      rx_toggle <= 1'b0;
    end else begin
      rx_word   <= next_rx_word;
      rx_toggle <= next_rx_toggle;
    end
  end

  // Rising-edge side: output position in mode 11
  always_comb begin
    next_rise_cnt = rise_cnt;
    if (rise_cnt < adsp_pkg::CNT_BITS'(adsp_pkg::WORD_BITS)) begin
      next_rise_cnt = rise_cnt + 1'b1;
    end
  end

  always_ff @(posedge link.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      rise_cnt <= '0;
    end else begin
      rise_cnt <= next_rise_cnt;
    end
  end

  // Output bit selection and three-state enable
  assign tx_idx = mode_s2 ? rise_cnt : fall_cnt;
  assign link.dout_drv = (tx_idx < adsp_pkg::CNT_BITS'(adsp_pkg::WORD_BITS)) ?
                         tx_word[adsp_pkg::WORD_BITS - 1 - int'(tx_idx)] : 1'b0;
  assign link.dout_oe  = ~link.cs_n;
  assign link.eoc_n    = eoc_n;

  // Core side events
  assign word_evt = tog_s2 ^ tog_s3;
  assign cs_rise  = cs_s2 & ~cs_s3;
  assign op       = rx_word[adsp_pkg::OP_MSB:adsp_pkg::OP_LSB];
  assign busy     = (state == ADSP_CONV);

  // DAC outputs follow input registers while update is low
  assign dac_value = link.dac_update_n ? dac_hold : dac_input;

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_eoc_n      = eoc_n;
    next_conv_start = 1'b0;
    next_tx_word    = tx_word;
    next_dac_input  = dac_input;
    next_dac_hold   = upd_s2 ? dac_hold : dac_input;
    if (cs_rise) begin
      next_eoc_n = 1'b1;
    end
    case (state)
      ADSP_INIT: begin
        next_cnt = cnt + 1'b1;
        if (cnt == 9'(adsp_pkg::SYNC_SETTLE)) begin
          for (int i = 0; i < NUM_DAC; i++) begin
            next_dac_input[i] = ps_s2 ? adsp_pkg::DAC_INIT_HIGH : adsp_pkg::DAC_INIT_LOW;
            next_dac_hold[i]  = ps_s2 ? adsp_pkg::DAC_INIT_HIGH : adsp_pkg::DAC_INIT_LOW;
          end
          next_cnt   = '0;
          next_state = ADSP_IDLE;
        end
      end
      ADSP_IDLE: begin
        if (word_evt) begin
          if (op == adsp_pkg::OP_CONVERT) begin
            next_conv_start = 1'b1;
            next_eoc_n      = 1'b1;
            next_cnt        = '0;
            next_state      = ADSP_CONV;
          end else if (int'(op) < NUM_DAC) begin
            next_dac_input[op[2:0]] = rx_word[adsp_pkg::VAL_MSB:adsp_pkg::VAL_LSB];
          end
        end
      end
      ADSP_CONV: begin
        next_cnt = cnt + 1'b1;
        if (cnt == 9'(adsp_pkg::CONV_CYCLES - 1)) begin
          next_tx_word = adsp_pkg::adsp_word_t'(conv_data);
          next_eoc_n   = 1'b0;
          next_state   = ADSP_IDLE;
        end
      end
      default: begin
        next_state = ADSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state      <= ADSP_INIT;
      cnt        <= '0;
      eoc_n      <= 1'b1;
      conv_start <= 1'b0;
      tx_word    <= '0;
      dac_input  <= '0;
      dac_hold   <= '0;
      tog_s1     <= 1'b0;
      tog_s2     <= 1'b0;
      tog_s3     <= 1'b0;
      cs_s1      <= 1'b1;
      cs_s2      <= 1'b1;
      cs_s3      <= 1'b1;
      ps_s1      <= 1'b0;
      ps_s2      <= 1'b0;
      upd_s1     <= 1'b1;
      upd_s2     <= 1'b1;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      eoc_n      <= next_eoc_n;
      conv_start <= next_conv_start;
      tx_word    <= next_tx_word;
      dac_input  <= next_dac_input;
      dac_hold   <= next_dac_hold;
      tog_s1     <= rx_toggle;
      tog_s2     <= tog_s1;
      tog_s3     <= tog_s2;
      cs_s1      <= link.cs_n;
      cs_s2      <= cs_s1;
      cs_s3      <= cs_s2;
      ps_s1      <= link.dac_powerup_select;
      ps_s2      <= ps_s1;
      upd_s1     <= link.dac_update_n;
      upd_s2     <= upd_s1;
    end
  end

endmodule

// ---- design/adsp_host.sv ----
// Host end: makes the serial clock by division, frames one 16-bit word per
// command and returns the word read back.
// Assumes the converter end sits on the same interface instance.
`timescale 1ns/100ps
module adsp_host (
  // Link pins
  adsp_if.host                    link,
  // System clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // Command side
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire adsp_pkg::adsp_word_t cmd_word,
  input  wire logic               cmd_wait_eoc,
  // Answer side
  output logic                    rsp_valid,
  output adsp_pkg::adsp_word_t    rsp_word,
  output logic                    result_ready,
  // Control pin requests
  input  wire logic               update_n_req,
  input  wire logic               powerup_select_req
);

  typedef enum {ADSP_H_IDLE, ADSP_H_WAIT, ADSP_H_SETUP, ADSP_H_HIGH, ADSP_H_LOW, ADSP_H_GAP} adsp_host_t;

  adsp_host_t                     state;
  adsp_host_t                     next_state;
  logic [3:0]                     cnt;
  logic [3:0]                     next_cnt;
  logic [adsp_pkg::CNT_BITS-1:0]  bits;
  logic [adsp_pkg::CNT_BITS-1:0]  next_bits;
  adsp_pkg::adsp_word_t           shift_out;
  adsp_pkg::adsp_word_t           next_shift_out;
  adsp_pkg::adsp_word_t           shift_in;
  adsp_pkg::adsp_word_t           next_shift_in;
  logic                           sclk;
  logic                           next_sclk;
  logic                           cs_n;
  logic                           next_cs_n;
  logic                           next_rsp_valid;
  adsp_pkg::adsp_word_t           next_rsp_word;
  logic                           eoc_s1;
  logic                           eoc_s2;
  logic                           dout_s1;
  logic                           dout_s2;
  logic                           update_n;
  logic                           powerup_select;

  assign cmd_ready               = (state == ADSP_H_IDLE);
  assign result_ready            = ~eoc_s2;
  assign link.sclk               = sclk;
  assign link.cs_n               = cs_n;
  assign link.din                = shift_out[adsp_pkg::WORD_BITS-1];
  assign link.dac_update_n       = update_n;
  assign link.dac_powerup_select = powerup_select;

  always_comb begin
    next_state     = state;
    next_cnt       = cnt + 1'b1;
    next_bits      = bits;
    next_shift_out = shift_out;
    next_shift_in  = shift_in;
    next_sclk      = sclk;
    next_cs_n      = cs_n;
    next_rsp_valid = 1'b0;
    next_rsp_word  = rsp_word;
    case (state)
      ADSP_H_IDLE: begin
        next_cnt = '0;
        if (cmd_valid) begin
          next_shift_out = cmd_word;
          next_bits      = '0;
          next_state     = cmd_wait_eoc ? ADSP_H_WAIT : ADSP_H_SETUP;
          next_cs_n      = cmd_wait_eoc;
        end
      end
      ADSP_H_WAIT: begin
        next_cnt = '0;
        if (!eoc_s2) begin
          next_cs_n  = 1'b0;
          next_state = ADSP_H_SETUP;
        end
      end
      ADSP_H_SETUP: begin
        if (cnt == 4'(adsp_pkg::HOST_HALF_CYCLES - 1)) begin
          next_sclk     = 1'b1;
          next_shift_in = {shift_in[adsp_pkg::WORD_BITS-2:0], dout_s2};
          next_cnt      = '0;
          next_state    = ADSP_H_HIGH;
        end
      end
      ADSP_H_HIGH: begin
        if (cnt == 4'(adsp_pkg::HOST_HALF_CYCLES - 1)) begin
          next_sclk  = 1'b0;
          next_bits  = bits + 1'b1;
          next_cnt   = '0;
          next_state = ADSP_H_LOW;
        end
      end
      ADSP_H_LOW: begin
        if (cnt == 4'(adsp_pkg::HOST_HALF_CYCLES - 1)) begin
          next_cnt = '0;
          if (bits == adsp_pkg::CNT_BITS'(adsp_pkg::WORD_BITS)) begin
            next_cs_n      = 1'b1;
            next_rsp_valid = 1'b1;
            next_rsp_word  = shift_in;
            next_state     = ADSP_H_GAP;
          end else begin
            next_sclk      = 1'b1;
            next_shift_out = {shift_out[adsp_pkg::WORD_BITS-2:0], 1'b0};
            next_shift_in  = {shift_in[adsp_pkg::WORD_BITS-2:0], dout_s2};
            next_state     = ADSP_H_HIGH;
          end
        end
      end
      ADSP_H_GAP: begin
        if (cnt == 4'(adsp_pkg::CS_HIGH_CYCLES + adsp_pkg::SYNC_SETTLE)) begin
          next_state = ADSP_H_IDLE;
        end
      end
      default: begin
        next_state = ADSP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state          <= ADSP_H_IDLE;
      cnt            <= '0;
      bits           <= '0;
      shift_out      <= '0;
      shift_in       <= '0;
      sclk           <= 1'b0;
      cs_n           <= 1'b1;
      rsp_valid      <= 1'b0;
      rsp_word       <= '0;
      eoc_s1         <= 1'b1;
      eoc_s2         <= 1'b1;
      dout_s1        <= 1'b0;
      dout_s2        <= 1'b0;
      update_n       <= 1'b1;
      powerup_select <= 1'b0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      bits           <= next_bits;
      shift_out      <= next_shift_out;
      shift_in       <= next_shift_in;
      sclk           <= next_sclk;
      cs_n           <= next_cs_n;
      rsp_valid      <= next_rsp_valid;
      rsp_word       <= next_rsp_word;
      eoc_s1         <= link.eoc_n;
      eoc_s2         <= eoc_s1;
      dout_s1        <= link.dout_line;
      dout_s2        <= dout_s1;
      update_n       <= update_n_req;
      powerup_select <= powerup_select_req;
    end
  end

endmodule

// ---- design/adsp_if.sv ----
// Serial port and control pins between the converter and its host.
// Assumes the bench connects this; the shared data line is gated here.
`timescale 1ns/100ps
interface adsp_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_drv;
  logic dout_oe;
  logic dout_line;
  logic eoc_n;
  logic dac_update_n;
  logic dac_powerup_select;

  // Released data line reads low
  assign dout_line = dout_oe & dout_drv;

  modport device (
    input  sclk, cs_n, din, dac_update_n, dac_powerup_select,
    output dout_drv, dout_oe, eoc_n
  );

  modport host (
    output sclk, cs_n, din, dac_update_n, dac_powerup_select,
    input  dout_line, eoc_n
  );
endinterface

// ---- design/adsp_pkg.sv ----
// Shared constants and types for the converter serial port, both ends.
// Assumes a 25 MHz system clock on both ends and 16-bit frames, MSB first.
package adsp_pkg;

  // Frame and register widths
  localparam int WORD_BITS = 16;
  localparam int DAC_BITS  = 12;
  localparam int ADC_BITS  = 10;
  localparam int NUM_DAC   = 8;
  localparam int CNT_BITS  = 5;

  // Command word fields
  localparam int OP_MSB  = 15;
  localparam int OP_LSB  = 12;
  localparam int VAL_MSB = 11;
  localparam int VAL_LSB = 0;
  localparam logic [3:0] OP_CONVERT = 4'h8;

  // Serial clock mode that shifts output on the rising edge
  localparam logic [1:0] MODE_RISE = 2'h3;

  // Power-up codes of the DAC input registers
  localparam logic [11:0] DAC_INIT_HIGH = 12'hfff;
  localparam logic [11:0] DAC_INIT_LOW  = 12'h000;

  // Timing
  localparam int CLOCK_PERIOD_NS  = 40;
  localparam int CONV_TIME_NS     = 9000;
  localparam int CONV_CYCLES      = (CONV_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CS_SETUP_NS      = 10;
  localparam int CS_SETUP_CYCLES  = (CS_SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CS_HIGH_NS       = 50;
  localparam int CS_HIGH_CYCLES   = (CS_HIGH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SYNC_SETTLE      = 2;
  localparam int HOST_HALF_CYCLES = 4;

  typedef logic [WORD_BITS-1:0] adsp_word_t;
  typedef logic [DAC_BITS-1:0]  adsp_dac_t;

endpackage

// ---- testbench/adsp_link_asserts.sv ----
// Checker on the serial link between the host end and the converter end.
// Assumes clock also drives the host that makes the serial clock; rst resets the converter end.
`timescale 1ns/100ps
module adsp_link_asserts (
  // System clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Link signals
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  input  wire logic       dout_drv,
  input  wire logic       dout_oe,
  input  wire logic       eoc_n,
  // Converter mode
  input  wire logic [1:0] clock_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Cycles with select high, and frames since the mode last changed
  logic [8:0] hi_cnt;
  logic [1:0] settled;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_cnt  <= 9'h000;
      settled <= 2'h0;
    end else begin
      hi_cnt <= cs_n ? hi_cnt + {8'h00, hi_cnt != 9'h1ff} : 9'h000;
      if ($changed(clock_mode)) settled <= 2'h0;
      else if ($rose(cs_n) && settled != 2'h3) settled <= settled + 2'h1;
    end
  end

  a_dout_off_idle:
    assert property (cs_n && $past(cs_n) |-> !dout_oe) else $error("Data out driven while deselected");
  a_dout_on_frame:
    assert property (!cs_n && !$past(cs_n) |-> dout_oe) else $error("Data out not driven in frame");
  a_shift_on_fall:
    assert property (!cs_n && !$past(cs_n, 3) && settled == 2'h3 && clock_mode != adsp_pkg::MODE_RISE
                     && $changed(dout_drv) |-> $fell(sclk)) else $error("Data out moved off a falling edge");
  a_shift_on_rise:
    assert property (!cs_n && !$past(cs_n, 3) && settled == 2'h3 && clock_mode == adsp_pkg::MODE_RISE
                     && $changed(dout_drv) |-> $rose(sclk)) else $error("Data out moved off a rising edge");
  a_din_stable_fall:
    assert property ($fell(sclk) |-> $stable(din)) else $error("Data in moved at the sampling edge");
  a_clock_in_frame:
    assert property ($changed(sclk) |-> !cs_n) else $error("Serial clock moved outside a frame");
  a_select_setup:
    assert property ($fell(cs_n) |-> !sclk [*3]) else $error("Serial clock too soon after select");
  a_eoc_release:
    assert property ($rose(cs_n) && !eoc_n |-> ##[1:8] eoc_n) else $error("End of conversion not released");
  a_eoc_latency:
    assert property ($fell(eoc_n) |-> hi_cnt inside {[9'h0dc:9'h0e8]}) else $error("Conversion time wrong");

  c_conversion: cover property ($fell(eoc_n));
  c_rise_mode: cover property (!cs_n && clock_mode == adsp_pkg::MODE_RISE && $changed(dout_drv));
  c_read_frame: cover property ($rose(cs_n) && !eoc_n);
endmodule

// ---- testbench/test_adc_dac_serial_pin_logic.sv ----
// Bench: host end facing a converter end, plus a second converter end driven pin by pin.
// Assumes the design package and interface are compiled first.
`timescale 1ns/100ps
module test_adc_dac_serial_pin_logic;
  logic                 clock;
  logic                 rst;
  logic                 rst_dev;
  logic                 cmd_valid;
  logic                 cmd_ready;
  adsp_pkg::adsp_word_t cmd_word;
  logic                 cmd_wait_eoc;
  logic                 rsp_valid;
  adsp_pkg::adsp_word_t rsp_word;
  logic                 result_ready;
  logic                 update_n_req;
  logic                 powerup_select_req;
  logic [1:0]           clock_mode;
  logic [9:0]           conv_data;
  logic                 busy;
  logic                 conv_start;
  logic [adsp_pkg::NUM_DAC-1:0][adsp_pkg::DAC_BITS-1:0] dac_a;
  logic [adsp_pkg::NUM_DAC-1:0][adsp_pkg::DAC_BITS-1:0] dac_b;
  adsp_pkg::adsp_word_t word_seen;
  logic [9:0]           cv;
  int                   miscompares;
  int                   n_checks;
  int                   n_starts;

  adsp_if link_a ();
  adsp_if link_b ();

  adsp_host i_adsp_host (.link(link_a), .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_word(cmd_word), .cmd_wait_eoc(cmd_wait_eoc), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
    .result_ready(result_ready), .update_n_req(update_n_req), .powerup_select_req(powerup_select_req));
  adsp_device i_adsp_device (.link(link_a), .clock(clock), .rst(rst_dev), .clock_mode(clock_mode),
    .conv_data(conv_data), .conv_start(conv_start), .busy(busy), .dac_value(dac_a));
  adsp_device i_adsp_device_b (.link(link_b), .clock(clock), .rst(rst_dev), .clock_mode(clock_mode),
    .conv_data(conv_data), .conv_start(), .busy(), .dac_value(dac_b));
  adsp_link_asserts i_adsp_link_asserts (.clock(clock), .rst(rst_dev), .sclk(link_a.sclk), .cs_n(link_a.cs_n),
    .din(link_a.din), .dout_drv(link_a.dout_drv), .dout_oe(link_a.dout_oe), .eoc_n(link_a.eoc_n),
    .clock_mode(clock_mode));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Conversion start pulses seen on the converter end
  always @(negedge clock) begin
    if (conv_start === 1'b1) begin
      n_starts <= n_starts + 1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One command through the host end, reply kept in word_seen
  task automatic send(input adsp_pkg::adsp_word_t w, input logic wait_eoc);
    int n;
    @(posedge clock);
    cmd_valid    <= 1'b1;
    cmd_word     <= w;
    cmd_wait_eoc <= wait_eoc;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    check({15'h0, cmd_ready}, 16'h0000);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (rsp_valid !== 1'b1 && n < 1000);
    check({15'h0, rsp_valid}, 16'h0001);
    word_seen = rsp_word;
  endtask

  // Pin-level frame on the second link, 48 ns serial clock
  task automatic bang(input logic [15:0] w, input int bits, input logic sel_n);
    @(posedge clock);
    link_b.cs_n <= sel_n;
    #37;
    for (int i = 0; i < bits; i++) begin
      link_b.din  <= w[15-i];
      link_b.sclk <= 1'b1;
      #24 link_b.sclk <= 1'b0;
      #24;
    end
    link_b.cs_n <= 1'b1;
    link_b.din  <= ~link_b.din;
    #400;
  endtask

  initial begin
    rst = 1'b1;
    rst_dev = 1'b1;
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    cmd_wait_eoc = 1'b0;
    update_n_req = 1'b1;
    powerup_select_req = 1'b0;
    clock_mode = 2'h0;
    conv_data = 10'h000;
    link_b.sclk = 1'b0;
    link_b.cs_n = 1'b1;
    link_b.din = 1'b0;
    link_b.dac_update_n = 1'b0;
    link_b.dac_powerup_select = 1'b0;
    miscompares = 0;
    n_checks = 0;
    n_starts = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rst_dev <= 1'b0;
    repeat (6) @(negedge clock);
    check({15'h0, link_a.dout_oe}, 16'h0000);
    check({15'h0, link_a.eoc_n}, 16'h0001);
    // Result read back in every serial clock mode
    for (int m = 0; m < 4; m++) begin
      cv = 10'h2c3 + 10'(m) * 10'h0a7;
      @(posedge clock);
      clock_mode <= 2'(m);
      conv_data  <= cv;
      send(16'hf000, 1'b0);
      send(16'hf000, 1'b0);
      send({adsp_pkg::OP_CONVERT, 12'h000}, 1'b0);
      check({15'h0, busy}, 16'h0001);
      repeat (250) @(negedge clock);
      check({15'h0, result_ready}, 16'h0001);
      check({15'h0, link_a.eoc_n}, 16'h0000);
      send(16'hf000, 1'b1);
      check(word_seen, {6'h00, cv});
      repeat (8) @(negedge clock);
      check({15'h0, link_a.eoc_n}, 16'h0001);
      check({15'h0, result_ready}, 16'h0000);
    end
    check(16'(n_starts), 16'h0004);
    // DAC writes held, then passed through
    for (int n = 0; n < 8; n++) send({4'(n), 12'(12'h1a5 + 12'(n) * 12'h111)}, 1'b0);
    repeat (8) @(negedge clock);
    for (int n = 0; n < 8; n++) check({4'h0, dac_a[n]}, 16'h0000);
    @(posedge clock);
    update_n_req <= 1'b0;
    repeat (4) @(negedge clock);
    for (int n = 0; n < 8; n++) check({4'h0, dac_a[n]}, {4'h0, 12'(12'h1a5 + 12'(n) * 12'h111)});
    // Second link: clocks while deselected, partial word, then a whole word
    bang(16'h0fff, 16, 1'b1);
    bang(16'h1abc, 8, 1'b0);
    bang(16'h2123, 16, 1'b0);
    repeat (10) @(negedge clock);
    check({4'h0, dac_b[0]}, 16'h0000);
    check({4'h0, dac_b[1]}, 16'h0000);
    check({4'h0, dac_b[2]}, 16'h0123);
    // Power-up codes from the select pin
    for (int p = 0; p < 2; p++) begin
      @(posedge clock);
      powerup_select_req <= (p == 0);
      repeat (3) @(posedge clock);
      rst_dev <= 1'b1;
      repeat (2) @(posedge clock);
      rst_dev <= 1'b0;
      repeat (8) @(negedge clock);
      for (int n = 0; n < 8; n++) check({4'h0, dac_a[n]}, (p == 0) ? 16'h0fff : 16'h0000);
    end
    final_report();
  end

  initial begin
    repeat (40000) @(posedge clock);
    $display("Error at %0t: watchdog expired", $time);
    miscompares++;
    final_report();
  end
endmodule
